// ==== tec_pkg.sv ====
// shared constants for the rx error checker: header fields, type codes, event bits
// assumes a 128-bit header beat laid out dword0 in the top 32 bits
package tec_pkg;
	// -------------------------------------------------------------
	// widths and depths
	// -------------------------------------------------------------
	localparam int HDR_W      = 128;
	localparam int BEAT_W     = HDR_W + 2;
	localparam int FIFO_DEPTH = 8;
	localparam int ERR_W      = 6;
	localparam int CNT_W      = 16;
	localparam int NBAR       = 2;
	// -------------------------------------------------------------
	// header field positions
	// -------------------------------------------------------------
	localparam int FMT_POS     = 125;
	localparam int TYPE_POS    = 120;
	localparam int EP_POS      = 110;
	localparam int RID_POS     = 80;
	localparam int TAG_POS     = 72;
	localparam int MSG_POS     = 64;
	localparam int CPL_RID_POS = 48;
	localparam int ADDR_HI_POS = 32;
	localparam int ADDR64_POS  = 0;
	localparam int ADDR32_POS  = 32;
	localparam int BUSDEV_LSB  = 3;
	localparam int BUSDEV_W    = 13;
	// -------------------------------------------------------------
	// type and message codes
	// -------------------------------------------------------------
	localparam logic [4:0] TY_MEM   = 5'h00;
	localparam logic [4:0] TY_MEMLK = 5'h01;
	localparam logic [4:0] TY_IO    = 5'h02;
	localparam logic [4:0] TY_CFG0  = 5'h04;
	localparam logic [4:0] TY_CFG1  = 5'h05;
	localparam logic [4:0] TY_CPL   = 5'h0A;
	localparam logic [4:0] TY_CPLLK = 5'h0B;
	localparam logic [1:0] TY_MSG   = 2'h2;
	localparam logic [7:0] MSG_OK_A = 8'h00;
	localparam logic [7:0] MSG_OK_B = 8'h50;
	// -------------------------------------------------------------
	// completion status and event bits
	// -------------------------------------------------------------
	localparam logic [2:0] CS_UR = 3'h1;
	localparam logic [2:0] CS_CA = 3'h4;
	localparam int EV_TIMEOUT = 0;
	localparam int EV_ABORT   = 1;
	localparam int EV_UNEXP   = 2;
	localparam int EV_POISON  = 3;
	localparam int EV_ECRC    = 4;
	localparam int EV_UR      = 5;
	// -------------------------------------------------------------
	// timing
	// -------------------------------------------------------------
	localparam int CLK_MHZ         = 100;
	localparam int CPL_TIMEOUT_US  = 50;
	localparam int CPL_TIMEOUT_CYC = CPL_TIMEOUT_US * CLK_MHZ;
endpackage

// ==== tec_rx_if.sv ====
// receive stream and error report vector between checker and application
// assumes both ends share ref_clk
`timescale 1ns/1ps
interface tec_rx_if;
	import tec_pkg::*;
	logic              rx_valid;
	logic              rx_ready;
	logic              rx_sop;
	logic              rx_eop;
	logic [HDR_W-1:0]  rx_word;
	logic [2:0]        cpl_err;
	modport dev (output rx_valid, rx_sop, rx_eop, rx_word, input rx_ready, cpl_err);
	modport app (input rx_valid, rx_sop, rx_eop, rx_word, output rx_ready, cpl_err);
endinterface

// ==== tec_dev.sv ====
// checker end: classifies received packets, drops rejects, answers rejected
// non-posted requests and logs every error event.
// assumes link beats are synchronous to ref_clk and ecrc result rides with the header beat
//
// Function
// - poisoned packets flagged, still delivered
// - application handles poisoned packets itself
// - ecrc failure raises non-fatal error
// - ecrc failed non-posted gets completer abort
// - ecrc failures and unsupported requests dropped
// - completion with foreign requester bus/device number unsupported (function bits not compared)
// - type 1 config, unknown message unsupported
// - locked read unsupported on native endpoint
// - locked completion unsupported
// - 64-bit address with zero upper half unsupported
// - memory or io missing all windows unsupported
// - unsupported non-posted gets unsupported completion
// - application times its own outstanding requests
// - application reports timeout on bit 0
// - application reports completer abort on bit 1
// - application reports unexpected completion on bit 2
// - foreign requester bus/device number also logs unexpected completion
// - poisoned packet updates error status itself
`timescale 1ns/1ps

// -------------------------------------------------------------
// receive buffer
// -------------------------------------------------------------
module tec_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         reset,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	// depth must be a power of two: pointers wrap by overflow
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} tec_fifo_st_t;
	tec_fifo_st_t s_r;
	tec_fifo_st_t s_nxt;
	logic         push;
	logic         pop;

	assign in_ready  = s_r.cnt != (AW+1)'(DEPTH);
	assign out_valid = s_r.cnt != '0;
	assign out_data  = s_r.mem[s_r.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wp] = in_data;
			s_nxt.wp = s_r.wp + 1'b1;
		end
		if (pop) begin
			s_nxt.rp = s_r.rp + 1'b1;
		end
		if (push && !pop) begin
			s_nxt.cnt = s_r.cnt + 1'b1;
		end else if (pop && !push) begin
			s_nxt.cnt = s_r.cnt - 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

// -------------------------------------------------------------
// checker end
// -------------------------------------------------------------
module tec_dev
	import tec_pkg::*;
(
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 reset,
	// link receive beats
	input  wire logic                 lnk_valid,
	output logic                      lnk_ready,
	input  wire logic                 lnk_sop,
	input  wire logic                 lnk_eop,
	input  wire logic [HDR_W-1:0]     lnk_word,
	input  wire logic                 lnk_ecrc_fail,
	// automatic completion toward the requester
	output logic                      acpl_valid,
	input  wire logic                 acpl_ready,
	output logic [2:0]                acpl_status,
	output logic [15:0]               acpl_req_id,
	output logic [7:0]                acpl_tag,
	// configuration
	input  wire logic [15:0]          cfg_req_id,
	input  wire logic                 cfg_native,
	input  wire logic [NBAR-1:0]      cfg_bar_en,
	input  wire logic [NBAR-1:0][31:0] cfg_bar_base,
	input  wire logic [NBAR-1:0][31:0] cfg_bar_mask,
	// error status
	input  wire logic                 stat_clr,
	output logic [ERR_W-1:0]          err_pulse,
	output logic [ERR_W-1:0]          err_status,
	output logic                      err_nonfatal,
	output logic [CNT_W-1:0]          err_count,
	// application side
	tec_rx_if.dev                     rx
);
	typedef struct packed {
		logic             drop;
		logic             cpl_valid;
		logic [2:0]       cpl_status;
		logic [15:0]      cpl_rid;
		logic [7:0]       cpl_tag;
		logic [ERR_W-1:0] pulse;
		logic [ERR_W-1:0] status;
		logic             nonfatal;
		logic [CNT_W-1:0] count;
	} tec_dev_st_t;
	tec_dev_st_t s_r;
	tec_dev_st_t s_nxt;

	logic [1:0]        fmt;
	logic [4:0]        ty;
	logic [31:0]       addr;
	logic              is_mem;
	logic              is_io;
	logic              is_cpl;
	logic              is_msg;
	logic              hi_zero;
	logic              bar_hit;
	logic              rid_bad;
	logic              msg_bad;
	logic              ur;
	logic              np;
	logic              reject;
	logic              skip;
	logic              take;
	logic              fifo_ready;
	logic [ERR_W-1:0]  ev;
	logic [CNT_W-1:0]  ev_sum;

	// -------------------------------------------------------------
	// header classification
	// -------------------------------------------------------------
	assign fmt     = lnk_word[FMT_POS +: 2];
	assign ty      = lnk_word[TYPE_POS +: 5];
	assign addr    = fmt[0] ? lnk_word[ADDR64_POS +: 32] : lnk_word[ADDR32_POS +: 32];
	assign is_mem  = (ty == TY_MEM) || (ty == TY_MEMLK);
	assign is_io   = ty == TY_IO;
	assign is_cpl  = (ty == TY_CPL) || (ty == TY_CPLLK);
	assign is_msg  = ty[4:3] == TY_MSG;
	assign hi_zero = is_mem && fmt[0] && (lnk_word[ADDR_HI_POS +: 32] == '0);
	assign rid_bad = is_cpl && (lnk_word[CPL_RID_POS + BUSDEV_LSB +: BUSDEV_W]
		!= cfg_req_id[BUSDEV_LSB +: BUSDEV_W]);
	assign msg_bad = is_msg && (lnk_word[MSG_POS +: 8] != MSG_OK_A)
		&& (lnk_word[MSG_POS +: 8] != MSG_OK_B);

	always_comb begin
		bar_hit = 1'b0;
		for (int i = 0; i < NBAR; i++) begin
			if (cfg_bar_en[i] && (((addr ^ cfg_bar_base[i]) & cfg_bar_mask[i]) == '0)) begin
				bar_hit = 1'b1;
			end
		end
	end

	assign ur = rid_bad || msg_bad
		|| (ty == TY_CFG1)
		|| ((ty == TY_MEMLK) && cfg_native)
		|| (ty == TY_CPLLK)
		|| hi_zero
		|| ((is_mem || is_io) && !bar_hit);
	assign np = (is_mem && !fmt[1]) || is_io || (ty == TY_CFG0) || (ty == TY_CFG1);

	// -------------------------------------------------------------
	// beat steering
	// -------------------------------------------------------------
	// a pending completion stalls the link so a second reject cannot overwrite it
	assign reject    = lnk_ecrc_fail || ur;
	assign skip      = lnk_sop ? reject : s_r.drop;
	assign lnk_ready = fifo_ready && !s_r.cpl_valid;
	assign take      = lnk_valid && lnk_ready;

	tec_fifo #(
		.W     (BEAT_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.in_valid  (lnk_valid && !s_r.cpl_valid && !skip),
		.in_ready  (fifo_ready),
		.in_data   ({lnk_sop, lnk_eop, lnk_word}),
		.out_valid (rx.rx_valid),
		.out_ready (rx.rx_ready),
		.out_data  ({rx.rx_sop, rx.rx_eop, rx.rx_word})
	);

	// -------------------------------------------------------------
	// events
	// -------------------------------------------------------------
	always_comb begin
		ev = '0;
		ev[2:0] = rx.cpl_err;
		if (take && lnk_sop) begin
			ev[EV_ECRC]   = lnk_ecrc_fail;
			ev[EV_UR]     = !lnk_ecrc_fail && ur;
			ev[EV_POISON] = !reject && lnk_word[EP_POS];
			ev[EV_UNEXP]  = rx.cpl_err[EV_UNEXP] || (!lnk_ecrc_fail && rid_bad);
		end
		ev_sum = '0;
		for (int i = 0; i < ERR_W; i++) begin
			ev_sum = ev_sum + CNT_W'(ev[i]);
		end
	end

	// -------------------------------------------------------------
	// next state
	// -------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		if (take && lnk_sop) begin
			s_nxt.drop = reject && !lnk_eop;
		end else if (take && lnk_eop) begin
			s_nxt.drop = 1'b0;
		end
		if (s_r.cpl_valid && acpl_ready) begin
			s_nxt.cpl_valid = 1'b0;
		end
		if (take && lnk_sop && reject && np) begin
			s_nxt.cpl_valid  = 1'b1;
			s_nxt.cpl_status = lnk_ecrc_fail ? CS_CA : CS_UR;
			s_nxt.cpl_rid    = lnk_word[RID_POS +: 16];
			s_nxt.cpl_tag    = lnk_word[TAG_POS +: 8];
		end
		s_nxt.pulse = ev;
		// a new event wins over a clear in the same cycle
		s_nxt.status   = (s_r.status & ~{ERR_W{stat_clr}}) | ev;
		s_nxt.nonfatal = (s_r.nonfatal && !stat_clr) || (|ev);
		s_nxt.count    = s_r.count + ev_sum;
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign acpl_valid   = s_r.cpl_valid;
	assign acpl_status  = s_r.cpl_status;
	assign acpl_req_id  = s_r.cpl_rid;
	assign acpl_tag     = s_r.cpl_tag;
	assign err_pulse    = s_r.pulse;
	assign err_status   = s_r.status;
	assign err_nonfatal = s_r.nonfatal;
	assign err_count    = s_r.count;
endmodule

// ==== tec_app.sv ====
// application end: consumes the receive stream, times one outstanding request
// and drives the completion error report vector.
// assumes a single outstanding request at a time
`timescale 1ns/1ps
module tec_app
	import tec_pkg::*;
#(
	parameter int TIMEOUT_CYC = CPL_TIMEOUT_CYC
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset,
	// user receive stream
	output logic                  usr_valid,
	input  wire logic             usr_ready,
	output logic                  usr_sop,
	output logic                  usr_eop,
	output logic [HDR_W-1:0]      usr_word,
	output logic                  usr_poison,
	// user request and abort
	input  wire logic             usr_req,
	output logic                  usr_busy,
	input  wire logic             usr_abort,
	output logic                  usr_timeout,
	// checker side
	tec_rx_if.app                 rx
);
	localparam int TW = $clog2(TIMEOUT_CYC + 1);
	typedef struct packed {
		logic          busy;
		logic [TW-1:0] timer;
		logic [2:0]    err;
	} tec_app_st_t;
	tec_app_st_t s_r;
	tec_app_st_t s_nxt;
	logic        cpl_seen;

	// -------------------------------------------------------------
	// stream pass-through
	// -------------------------------------------------------------
	assign usr_valid  = rx.rx_valid;
	assign rx.rx_ready = usr_ready;
	assign usr_sop    = rx.rx_sop;
	assign usr_eop    = rx.rx_eop;
	assign usr_word   = rx.rx_word;
	// poisoned payload is only marked; the user decides what to do with it
	assign usr_poison = rx.rx_valid && rx.rx_sop && rx.rx_word[EP_POS];
	assign cpl_seen   = rx.rx_valid && usr_ready && rx.rx_sop
		&& ((rx.rx_word[TYPE_POS +: 5] == TY_CPL) || (rx.rx_word[TYPE_POS +: 5] == TY_CPLLK));

	// -------------------------------------------------------------
	// request timer and error reports
	// -------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.err = '0;
		s_nxt.err[EV_ABORT] = usr_abort;
		if (s_r.busy) begin
			s_nxt.timer = s_r.timer + 1'b1;
			if (cpl_seen) begin
				s_nxt.busy = 1'b0;
			end else if (s_r.timer == TW'(TIMEOUT_CYC - 1)) begin
				s_nxt.busy = 1'b0;
				s_nxt.err[EV_TIMEOUT] = 1'b1;
			end
		end else begin
			s_nxt.err[EV_UNEXP] = cpl_seen;
			if (usr_req) begin
				s_nxt.busy  = 1'b1;
				s_nxt.timer = '0;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rx.cpl_err  = s_r.err;
	assign usr_busy    = s_r.busy;
	assign usr_timeout = s_r.err[EV_TIMEOUT];
endmodule

// ==== tec_chk_sva.sv ====
// concurrent checks on the rx stream, report vector and error outputs
// assumes one ref_clk domain and an asynchronous active high reset
`timescale 1ns/1ps
module tec_chk_sva
	import tec_pkg::*;
(
	// clock and reset
	input wire logic             ref_clk,
	input wire logic             reset,
	// stream and report vector
	input wire logic             rx_valid,
	input wire logic             rx_ready,
	input wire logic             rx_sop,
	input wire logic [HDR_W-1:0] rx_word,
	input wire logic [2:0]       cpl_err,
	input wire logic             usr_poison,
	// link and automatic completion
	input wire logic             lnk_valid,
	input wire logic             lnk_ready,
	input wire logic             lnk_ecrc_fail,
	input wire logic             acpl_valid,
	input wire logic             acpl_ready,
	input wire logic [2:0]       acpl_status,
	// error status
	input wire logic             stat_clr,
	input wire logic [ERR_W-1:0] err_pulse,
	input wire logic [ERR_W-1:0] err_status,
	input wire logic             err_nonfatal
);
	// ----
	// properties
	// ----
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	a_stream_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
		else $error("rx beat changed while stalled");
	a_poison_shown: assert property (rx_valid && rx_sop |-> usr_poison == rx_word[EP_POS])
		else $error("poison flag differs from header");
	a_report_logged: assert property (|cpl_err |=> (err_pulse[2:0] & $past(cpl_err)) == $past(cpl_err))
		else $error("reported event not logged");
	a_timeout_single: assert property (cpl_err[EV_TIMEOUT] |=> !cpl_err[EV_TIMEOUT])
		else $error("timeout report longer than one cycle");
	a_ecrc_first: assert property (lnk_valid && lnk_ready && lnk_ecrc_fail |=> err_pulse[EV_ECRC] && !err_pulse[EV_UR])
		else $error("ecrc failure not logged alone");
	a_answer_hold: assert property (acpl_valid && !acpl_ready |=> acpl_valid && $stable(acpl_status))
		else $error("automatic completion dropped early");
	a_answer_gate: assert property (acpl_valid |-> !lnk_ready)
		else $error("link taken while completion pending");
	a_nonfatal_set: assert property (|err_pulse && !stat_clr |=> err_nonfatal)
		else $error("event without non-fatal flag");
	a_status_kept: assert property (!stat_clr |=> ($past(err_status) & ~err_status) == '0)
		else $error("status bit lost without clear");
	a_status_set: assert property (|err_pulse && !stat_clr |=> (err_status & $past(err_pulse)) == $past(err_pulse))
		else $error("event missing from status");
endmodule

// ==== tb.sv ====
// self-checking bench: checker end and application end joined by tec_rx_if
// assumes a 100 MHz ref_clk; bars and own id are fixed for the whole run
`timescale 1ns/1ps
module tb;
	import tec_pkg::*;
	localparam int TO = 20;
	localparam logic [15:0] MY_ID = 16'h0100;
	localparam logic [NBAR-1:0][31:0] BASE = {32'h8000_0000, 32'h4000_0000};
	localparam logic [NBAR-1:0][31:0] MASK = {32'hFF00_0000, 32'hF000_0000};
	localparam logic [71:0] HIT = {8'h00, 32'h4000_0010, 32'h0000_0000};
	localparam logic [71:0] MISS = {8'h00, 32'h2000_0000, 32'h0000_0000};
	localparam logic [6:0] MRD3 = {2'h0, TY_MEM};
	localparam logic [6:0] MWR3 = {2'h2, TY_MEM};
	localparam logic [6:0] CPL = {2'h0, TY_CPL};
	localparam logic [6:0] MSG = {2'h1, TY_MSG, 3'h0};
	logic ref_clk, reset, lnk_valid, lnk_ready, lnk_ecrc_fail, acpl_valid, acpl_ready;
	logic stat_clr, err_nonfatal, usr_ready, usr_poison, usr_req, usr_busy, usr_abort;
	logic usr_timeout, usr_valid, usr_sop, usr_eop, cfg_native;
	logic [HDR_W-1:0] usr_word;
	logic [2:0] acpl_status;
	logic [15:0] acpl_req_id;
	logic [7:0] acpl_tag;
	logic [HDR_W-1:0] lnk_word;
	logic [ERR_W-1:0] err_pulse, err_status;
	logic [CNT_W-1:0] err_count, c0;
	int fail_count, n_tests, n;
	tec_rx_if rx_if ();
	tec_dev tec_dev_i (.ref_clk, .reset, .lnk_valid, .lnk_ready, .lnk_sop(lnk_valid),
		.lnk_eop(lnk_valid), .lnk_word, .lnk_ecrc_fail, .acpl_valid, .acpl_ready, .acpl_status,
		.acpl_req_id, .acpl_tag, .cfg_req_id(MY_ID), .cfg_native, .cfg_bar_en(2'h3),
		.cfg_bar_base(BASE), .cfg_bar_mask(MASK), .stat_clr, .err_pulse, .err_status,
		.err_nonfatal, .err_count, .rx(rx_if));
	tec_app #(.TIMEOUT_CYC(TO)) tec_app_i (.ref_clk, .reset, .usr_valid, .usr_ready,
		.usr_sop, .usr_eop, .usr_word, .usr_poison, .usr_req, .usr_busy, .usr_abort,
		.usr_timeout, .rx(rx_if));
	tec_chk_sva tec_chk_sva_i (.ref_clk, .reset, .rx_valid(rx_if.rx_valid),
		.rx_ready(rx_if.rx_ready), .rx_sop(rx_if.rx_sop), .rx_word(rx_if.rx_word),
		.cpl_err(rx_if.cpl_err), .usr_poison, .lnk_valid, .lnk_ready, .lnk_ecrc_fail,
		.acpl_valid, .acpl_ready, .acpl_status, .stat_clr, .err_pulse, .err_status,
		.err_nonfatal);
	// ----
	// helpers
	// ----
	function automatic logic [HDR_W-1:0] hdr(input logic [6:0] ft, input logic [71:0] lo);
		hdr = '0;
		hdr[TYPE_POS+:7] = ft;
		hdr[RID_POS+:16] = 16'h1A2B;
		hdr[TAG_POS+:8] = 8'h5C;
		hdr[71:0] = lo;
	endfunction
	task automatic chk(input string nm, input logic [HDR_W-1:0] seen, input logic [HDR_W-1:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict;
		if (fail_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// one single-beat packet; st 0 means no automatic completion expected
	task automatic xfer(input logic [HDR_W-1:0] h, input logic ec, input logic [ERR_W-1:0] ep,
		input logic dlv, input logic [2:0] st);
		int k;
		@(negedge ref_clk);
		lnk_valid = 1;
		lnk_word = h;
		lnk_ecrc_fail = ec;
		k = 0;
		while (lnk_ready !== 1'b1 && k < 50) begin
			@(negedge ref_clk);
			k++;
		end
		chk("lnk_ready", lnk_ready, 1'b1);
		@(negedge ref_clk);
		lnk_valid = 0;
		lnk_ecrc_fail = 0;
		chk("err_pulse", err_pulse, ep);
		chk("rx_valid", rx_if.rx_valid, dlv);
		chk("usr_valid", usr_valid, dlv);
		if (dlv) chk("usr_frame", {usr_sop, usr_eop}, 2'h3);
		if (dlv && usr_ready) chk("usr_word", usr_word, h);
		if (dlv && usr_ready) chk("rx_word", rx_if.rx_word, h);
		if (dlv && usr_ready) chk("usr_poison", usr_poison, h[EP_POS]);
		chk("acpl_valid", acpl_valid, st != 3'h0);
		if (st != 3'h0) begin
			chk("acpl_status", acpl_status, st);
			chk("acpl_id", {acpl_req_id, acpl_tag}, 24'h1A2B5C);
			repeat (3) @(negedge ref_clk);
			acpl_ready = 1;
			@(negedge ref_clk);
			acpl_ready = 0;
			chk("acpl_done", acpl_valid, 1'b0);
		end
	endtask
	task automatic pulse_count(input int b, input int cyc, output int cnt);
		cnt = 0;
		repeat (cyc) begin
			@(negedge ref_clk);
			if (err_pulse[b] === 1'b1) cnt++;
		end
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_poison;
		logic [HDR_W-1:0] h;
		h = hdr(MWR3, HIT);
		h[EP_POS] = 1'b1;
		xfer(h, 1'b0, 6'h08, 1'b1, 3'h0);
		chk("poison_status", {err_status[EV_POISON], err_nonfatal}, 2'h3);
	endtask
	task automatic t_clr;
		@(negedge ref_clk);
		stat_clr = 1;
		@(negedge ref_clk);
		stat_clr = 0;
		chk("cleared", {err_status, err_nonfatal}, '0);
	endtask
	task automatic t_ecrc;
		xfer(hdr(MRD3, HIT), 1'b1, 6'h10, 1'b0, CS_CA);
		xfer(hdr(MWR3, HIT), 1'b1, 6'h10, 1'b0, 3'h0);
		xfer(hdr(MRD3, MISS), 1'b1, 6'h10, 1'b0, CS_CA);
	endtask
	task automatic t_ur;
		logic [6:0] ft [8] = '{CPL, MSG, {2'h0, TY_CFG1}, {2'h0, TY_MEMLK}, {2'h0, TY_CPLLK},
			{2'h1, TY_MEM}, MRD3, {2'h0, TY_IO}};
		logic [71:0] lo [8] = '{{8'h00, 16'h0208, 48'h0}, {8'h33, 64'h0}, HIT, HIT,
			{8'h00, MY_ID, 48'h0}, {8'h00, 32'h0, 32'h4000_0010}, MISS, {8'h00, 32'h1000, 32'h0}};
		logic [2:0] st [8] = '{3'h0, 3'h0, CS_UR, CS_UR, 3'h0, CS_UR, CS_UR, CS_UR};
		for (int i = 0; i < 8; i++) begin
			xfer(hdr(ft[i], lo[i]), 1'b0, i == 0 ? 6'h24 : 6'h20, 1'b0, st[i]);
		end
		xfer(hdr(MSG, {8'h50, 64'h0}), 1'b0, 6'h00, 1'b1, 3'h0);
		xfer(hdr(MRD3, HIT), 1'b0, 6'h00, 1'b1, 3'h0);
		xfer(hdr(MSG, 72'h0), 1'b0, 6'h00, 1'b1, 3'h0);
		cfg_native = 0;
		xfer(hdr({2'h0, TY_MEMLK}, HIT), 1'b0, 6'h00, 1'b1, 3'h0);
		cfg_native = 1;
	endtask
	task automatic t_app;
		int cnt;
		@(negedge ref_clk);
		usr_req = 1;
		@(negedge ref_clk);
		usr_req = 0;
		c0 = err_count;
		n = 0;
		while (usr_timeout !== 1'b1 && n < 40) begin
			@(negedge ref_clk);
			n++;
		end
		chk("timeout_at", n, TO);
		chk("busy_off", usr_busy, 1'b0);
		pulse_count(EV_TIMEOUT, 3, cnt);
		chk("timeout_pulses", cnt, 1);
		chk("err_count", err_count, c0 + 16'h1);
		@(negedge ref_clk);
		usr_abort = 1;
		@(negedge ref_clk);
		usr_abort = 0;
		pulse_count(EV_ABORT, 3, cnt);
		chk("abort_pulses", cnt, 1);
		usr_req = 1;
		@(negedge ref_clk);
		usr_req = 0;
		xfer(hdr(CPL, {8'h00, MY_ID, 48'h0}), 1'b0, 6'h00, 1'b1, 3'h0);
		pulse_count(EV_UNEXP, 4, cnt);
		chk("expected_cpl", {usr_busy, cnt[1:0]}, 3'h0);
		xfer(hdr(CPL, {8'h00, MY_ID, 48'h0}), 1'b0, 6'h00, 1'b1, 3'h0);
		pulse_count(EV_UNEXP, 4, cnt);
		chk("unexpected_cpl", cnt, 1);
	endtask
	task automatic t_fill;
		usr_ready = 0;
		for (int i = 0; i < FIFO_DEPTH; i++) xfer(hdr(MWR3, HIT + i), 1'b0, 6'h00, 1'b1, 3'h0);
		chk("full_refuse", lnk_ready, 1'b0);
		usr_ready = 1;
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			chk("drain_word", rx_if.rx_word, hdr(MWR3, HIT + i));
			@(negedge ref_clk);
		end
		chk("drained", rx_if.rx_valid, 1'b0);
	endtask
	// ----
	// run
	// ----
	initial begin
		ref_clk = 0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (3000) @(posedge ref_clk);
		fail_count++;
		print_verdict();
	end
	initial begin
		{lnk_valid, lnk_ecrc_fail, acpl_ready, stat_clr, usr_req, usr_abort} = '0;
		{lnk_word, fail_count, n_tests} = '0;
		usr_ready = 1;
		cfg_native = 1;
		reset = 1;
		repeat (10) @(negedge ref_clk);
		reset = 0;
		t_poison();
		t_clr();
		t_ecrc();
		t_ur();
		t_app();
		t_fill();
		t_clr();
		print_verdict();
	end
endmodule
